/* src/uawd_top.sv */
// usb activity watchdog with axi4-lite register slave
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none

// How it works
// RL1: armed with action runs counter; commands restart
// RL2: count reaching period fires enabled actions
// RL3: only host commands restart, never outbound stream
// RL4: expiry resets device, drives line, or both
// RL5: host sets expiry line direction to output
// RL6: arm carries 1-65535 seconds, 16-bit counter
// RL7: config kept in storage, reloaded after reset
// RL8: host avoids rapid arm/disarm storage rewrites
// RL9: options staged, sent with arm or disarm
// RL10: four options: reset, line, select, level
// RL11: disarm stops counter, suppresses actions, stores
// RL12: strap short at power-up restores factory disarmed
// RL13: prescaler makes seconds; arm restarts both
// RL14: line-only expiry restarts count, stays armed
module uawd_top #(
  parameter int SECOND_CYCLES = uawd_pkg::SECOND_CYCLES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic host_cmd_pulse,
  input wire logic strap_short,
  input wire uawd_pkg::uawd_cfg_t nv_load_data,
  output uawd_pkg::uawd_cfg_t nv_store_data,
  output logic nv_store_valid,
  input wire logic nv_store_ready,
  output logic device_reset_req,
  output logic expiry_line_write,
  output logic [uawd_pkg::SEL_W-1:0] expiry_line_select,
  output logic expiry_line_level,
  output logic irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  uawd_pkg::uawd_cfg_t options_ff, nxt_options;
  uawd_pkg::uawd_cfg_t cfg_ff, nxt_cfg;
  logic [uawd_pkg::IRQ_W-1:0] irq_stat_ff, nxt_irq_stat;
  logic [uawd_pkg::IRQ_W-1:0] irq_mask_ff, nxt_irq_mask;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  uawd_pkg::uawd_state_t state_ff, nxt_state;
  logic [31:0] presc_ff, nxt_presc;
  logic [uawd_pkg::SEC_W-1:0] sec_ff, nxt_sec;
  logic nv_valid_ff, nxt_nv_valid;
  uawd_pkg::uawd_cfg_t nv_data_ff, nxt_nv_data;
  logic reset_req_ff, nxt_reset_req;
  logic line_wr_ff, nxt_line_wr;
  logic [uawd_pkg::SEL_W-1:0] line_sel_ff, nxt_line_sel;
  logic line_lvl_ff, nxt_line_lvl;

  logic wr_take, rd_take;
  logic [31:0] wmask, wmasked, opt_wr;
  logic arm_req, disarm_req, bad_time;
  logic [uawd_pkg::IRQ_W-1:0] irq_set, irq_clr;
  logic active, tick, expire;

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  assign wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
  assign rd_take = s_axi_arvalid && !rvalid_ff;
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign s_axi_arready = rd_take;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  generate
    for (genvar b = 0; b < 4; b++) begin : g_strb
      assign wmask[8*b +: 8] = {8{s_axi_wstrb[b]}};
    end
  endgenerate
  assign wmasked = s_axi_wdata & wmask;
  // struct fields to their register bit positions
  function automatic logic [31:0] cfg_word(input uawd_pkg::uawd_cfg_t c);
    cfg_word = '0;
    cfg_word[uawd_pkg::BIT_ARMED] = c.armed;
    cfg_word[uawd_pkg::BIT_RESET_EN] = c.reset_on_expiry;
    cfg_word[uawd_pkg::BIT_LINE_EN] = c.line_update_on_expiry;
    cfg_word[uawd_pkg::BIT_LINE_LEVEL] = c.expiry_line_level;
    cfg_word[uawd_pkg::SEL_LSB +: uawd_pkg::SEL_W] = c.expiry_line_select;
    cfg_word[uawd_pkg::SEC_LSB +: uawd_pkg::SEC_W] = c.expiry_seconds;
  endfunction
  assign opt_wr = (cfg_word(options_ff) & ~wmask) | wmasked;

  // config request decode
  always_comb begin
    arm_req = 1'b0;
    disarm_req = 1'b0;
    bad_time = 1'b0;
    if (wr_take && s_axi_awaddr == uawd_pkg::ADDR_CONFIG_REQ && state_ff == uawd_pkg::ST_RUN) begin
      if (wmasked[uawd_pkg::BIT_REQ_DISARM]) begin
        disarm_req = 1'b1;
      end else if (wmasked[uawd_pkg::BIT_REQ_ARM]) begin
        if (wmasked[uawd_pkg::SEC_LSB +: uawd_pkg::SEC_W] == uawd_pkg::SEC_ZERO) begin
          bad_time = 1'b1; // RL6
        end else begin
          arm_req = 1'b1;
        end
      end
    end
  end

  always_comb begin
    nxt_options = options_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_bvalid = bvalid_ff && !s_axi_bready;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff && !s_axi_rready;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    irq_clr = '0;
    if (wr_take) begin
      nxt_bvalid = 1'b1;
      nxt_bresp = uawd_pkg::RESP_OKAY;
      case (s_axi_awaddr)
        uawd_pkg::ADDR_OPTIONS: begin
          // staged until the next arm or disarm request
          nxt_options.reset_on_expiry = opt_wr[uawd_pkg::BIT_RESET_EN]; // RL9 RL10
          nxt_options.line_update_on_expiry = opt_wr[uawd_pkg::BIT_LINE_EN]; // RL10
          nxt_options.expiry_line_level = opt_wr[uawd_pkg::BIT_LINE_LEVEL]; // RL10
          nxt_options.expiry_line_select = opt_wr[uawd_pkg::SEL_LSB +: uawd_pkg::SEL_W]; // RL10
          nxt_options.expiry_seconds = opt_wr[uawd_pkg::SEC_LSB +: uawd_pkg::SEC_W];
        end
        uawd_pkg::ADDR_CONFIG_REQ: begin
        end
        uawd_pkg::ADDR_IRQ_STATUS: begin
          irq_clr = wmasked[uawd_pkg::IRQ_W-1:0];
        end
        uawd_pkg::ADDR_IRQ_MASK: begin
          nxt_irq_mask = (irq_mask_ff & ~wmask[uawd_pkg::IRQ_W-1:0])
            | wmasked[uawd_pkg::IRQ_W-1:0];
        end
        default: begin
          nxt_bresp = uawd_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (rd_take) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = uawd_pkg::RESP_OKAY;
      nxt_rdata = '0;
      case (s_axi_araddr)
        uawd_pkg::ADDR_OPTIONS: nxt_rdata = cfg_word(options_ff);
        uawd_pkg::ADDR_CONFIG_REQ: nxt_rdata = '0;
        uawd_pkg::ADDR_STATUS: begin
          nxt_rdata[uawd_pkg::BIT_ARMED] = cfg_ff.armed;
          nxt_rdata[uawd_pkg::BIT_STAT_NV_BUSY] = nv_valid_ff;
          nxt_rdata[uawd_pkg::SEC_LSB +: uawd_pkg::SEC_W] = sec_ff;
        end
        uawd_pkg::ADDR_IRQ_STATUS: nxt_rdata[uawd_pkg::IRQ_W-1:0] = irq_stat_ff;
        uawd_pkg::ADDR_IRQ_MASK: nxt_rdata[uawd_pkg::IRQ_W-1:0] = irq_mask_ff;
        uawd_pkg::ADDR_ACTIVE: nxt_rdata = cfg_word(cfg_ff);
        default: nxt_rresp = uawd_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      options_ff <= uawd_pkg::CFG_FACTORY;
      irq_mask_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= uawd_pkg::RESP_OKAY;
      rvalid_ff <= 1'b0;
      rresp_ff <= uawd_pkg::RESP_OKAY;
      rdata_ff <= '0;
    end else begin
      options_ff <= nxt_options;
      irq_mask_ff <= nxt_irq_mask;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------
  always_comb begin
    irq_set = '0;
    irq_set[uawd_pkg::IRQ_EXPIRY] = expire;
    irq_set[uawd_pkg::IRQ_NV_STORED] = nv_valid_ff && nv_store_ready;
    irq_set[uawd_pkg::IRQ_BAD_TIME] = bad_time;
    // set wins over a clear in the same cycle
    nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  // ----------------------------------------------------------------
  // watchdog core
  // ----------------------------------------------------------------
  assign active = cfg_ff.armed && (cfg_ff.reset_on_expiry || cfg_ff.line_update_on_expiry);
  assign tick = presc_ff == 32'(SECOND_CYCLES - 1); // RL13
  assign expire = state_ff == uawd_pkg::ST_RUN && active && !host_cmd_pulse && !arm_req
    && !disarm_req && tick && (sec_ff + 16'h0001) == cfg_ff.expiry_seconds; // RL2 RL6

  always_comb begin
    nxt_state = state_ff;
    nxt_cfg = cfg_ff;
    nxt_presc = presc_ff;
    nxt_sec = sec_ff;
    nxt_nv_valid = nv_valid_ff && !nv_store_ready;
    nxt_nv_data = nv_data_ff;
    nxt_reset_req = 1'b0;
    nxt_line_wr = 1'b0;
    nxt_line_sel = line_sel_ff;
    nxt_line_lvl = line_lvl_ff;
    case (state_ff)
      uawd_pkg::ST_LOAD: begin
        nxt_state = uawd_pkg::ST_RUN;
        if (strap_short) begin
          nxt_cfg = uawd_pkg::CFG_FACTORY; // RL12
          nxt_nv_data = uawd_pkg::CFG_FACTORY; // RL12
          nxt_nv_valid = 1'b1;
        end else begin
          nxt_cfg = nv_load_data; // RL7
        end
      end
      uawd_pkg::ST_RUN: begin
        if (disarm_req) begin
          nxt_cfg = options_ff;
          nxt_cfg.armed = 1'b0; // RL11
          nxt_cfg.expiry_seconds = cfg_ff.expiry_seconds;
          nxt_presc = '0; // RL11
          nxt_sec = '0;
          nxt_nv_data = nxt_cfg; // RL7 RL11
          nxt_nv_valid = 1'b1;
        end else if (arm_req) begin
          nxt_cfg = options_ff; // RL9
          nxt_cfg.armed = 1'b1;
          nxt_cfg.expiry_seconds = wmasked[uawd_pkg::SEC_LSB +: uawd_pkg::SEC_W]; // RL6
          nxt_presc = '0; // RL13
          nxt_sec = '0; // RL13
          nxt_nv_data = nxt_cfg; // RL7
          nxt_nv_valid = 1'b1;
        end else if (!active || host_cmd_pulse) begin
          // outbound stream traffic has no path here
          nxt_presc = '0; // RL1 RL3
          nxt_sec = '0; // RL1
        end else if (tick) begin
          nxt_presc = '0;
          if (expire) begin
            nxt_sec = '0; // RL14
            nxt_reset_req = cfg_ff.reset_on_expiry; // RL4
            nxt_line_wr = cfg_ff.line_update_on_expiry; // RL4
            if (cfg_ff.line_update_on_expiry) begin
              nxt_line_sel = cfg_ff.expiry_line_select; // RL4
              nxt_line_lvl = cfg_ff.expiry_line_level; // RL4
            end
          end else begin
            nxt_sec = sec_ff + 16'h0001; // RL6
          end
        end else begin
          nxt_presc = presc_ff + 32'h00000001; // RL13
        end
      end
      default: begin
        nxt_state = uawd_pkg::ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= uawd_pkg::ST_LOAD;
      cfg_ff <= uawd_pkg::CFG_FACTORY;
      presc_ff <= '0;
      sec_ff <= '0;
      nv_valid_ff <= 1'b0;
      nv_data_ff <= uawd_pkg::CFG_FACTORY;
      reset_req_ff <= 1'b0;
      line_wr_ff <= 1'b0;
      line_sel_ff <= '0;
      line_lvl_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cfg_ff <= nxt_cfg;
      presc_ff <= nxt_presc;
      sec_ff <= nxt_sec;
      nv_valid_ff <= nxt_nv_valid;
      nv_data_ff <= nxt_nv_data;
      reset_req_ff <= nxt_reset_req;
      line_wr_ff <= nxt_line_wr;
      line_sel_ff <= nxt_line_sel;
      line_lvl_ff <= nxt_line_lvl;
    end
  end

  assign nv_store_valid = nv_valid_ff;
  assign nv_store_data = nv_data_ff;
  assign device_reset_req = reset_req_ff;
  assign expiry_line_write = line_wr_ff;
  assign expiry_line_select = line_sel_ff;
  assign expiry_line_level = line_lvl_ff;

endmodule
`default_nettype wire

/* src/uawd_pkg.sv */
// shared constants and types of the usb activity watchdog
package uawd_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_OPTIONS = 8'h00;
  localparam logic [7:0] ADDR_CONFIG_REQ = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_ACTIVE = 8'h14;
  localparam int ADDR_W = 8;

  // ----------------------------------------------------------------
  // field layout (options, active config, config request, status)
  // ----------------------------------------------------------------
  localparam int BIT_ARMED = 0;
  localparam int BIT_RESET_EN = 1;
  localparam int BIT_LINE_EN = 2;
  localparam int BIT_LINE_LEVEL = 3;
  localparam int SEL_LSB = 8;
  localparam int SEL_W = 5;
  localparam int SEC_LSB = 16;
  localparam int SEC_W = 16;
  localparam int BIT_REQ_ARM = 0;
  localparam int BIT_REQ_DISARM = 1;
  localparam int BIT_STAT_NV_BUSY = 1;

  // interrupt status / mask bits
  localparam int IRQ_W = 3;
  localparam int IRQ_EXPIRY = 0;
  localparam int IRQ_NV_STORED = 1;
  localparam int IRQ_BAD_TIME = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] SEC_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 50000000;
  localparam longint TICK_SECONDS = 1;
  localparam int SECOND_CYCLES_DEF = int'(CLK_HZ * TICK_SECONDS);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [SEC_W-1:0] expiry_seconds;
    logic [SEL_W-1:0] expiry_line_select;
    logic expiry_line_level;
    logic line_update_on_expiry;
    logic reset_on_expiry;
    logic armed;
  } uawd_cfg_t;

  localparam uawd_cfg_t CFG_FACTORY = '0;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b01,
    ST_RUN = 2'b10
  } uawd_state_t;

endpackage

/* testbench/uawd_nv_model.sv */
// non-volatile config store model
`timescale 1ns/1ns
`default_nettype none
module uawd_nv_model (
  input wire logic aclk,
  input wire logic slow,
  input wire uawd_pkg::uawd_cfg_t nv_store_data,
  input wire logic nv_store_valid,
  output logic nv_store_ready,
  output uawd_pkg::uawd_cfg_t nv_load_data
);
  logic [1:0] wait_ff = 2'h0;
  initial nv_store_ready = 1'h0;
  // contents survive device reset and are offered at every load
  initial nv_load_data = uawd_pkg::CFG_FACTORY;
  // slow mode stalls each erase and rewrite
  always @(posedge aclk) begin
    wait_ff <= (nv_store_valid && !nv_store_ready) ? wait_ff + 2'h1 : 2'h0;
    nv_store_ready <= nv_store_valid && !nv_store_ready && (!slow || wait_ff == 2'h3);
    if (nv_store_valid && nv_store_ready) nv_load_data <= nv_store_data;
  end
endmodule
`default_nettype wire

/* testbench/uawd_checker.sv */
// port-level assertions of the watchdog top
`timescale 1ns/1ns
`default_nettype none
module uawd_checker #(
  parameter int SECOND_CYCLES = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rready,
  input wire logic host_cmd_pulse,
  input wire logic nv_store_valid,
  input wire logic nv_store_ready,
  input wire logic device_reset_req,
  input wire logic expiry_line_write,
  input wire logic [uawd_pkg::SEL_W-1:0] expiry_line_select,
  input wire logic expiry_line_level
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  write_answer_a: assert property (
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid) else $error("no bvalid");
  read_answer_a: assert property (
    s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid) else $error("no rvalid");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata");
  cmd_restart_a: assert property (
    host_cmd_pulse |-> ##2 !(device_reset_req || expiry_line_write) [*3]) else $error("restart");
  reset_pulse_a: assert property (
    device_reset_req |=> !device_reset_req) else $error("reset pulse width");
  line_pulse_a: assert property (
    expiry_line_write |=> !expiry_line_write) else $error("line pulse width");
  line_hold_a: assert property (
    $changed(expiry_line_select) || $changed(expiry_line_level) |-> expiry_line_write)
    else $error("line level moved");
  nv_hold_a: assert property (
    nv_store_valid && !nv_store_ready |=> nv_store_valid) else $error("store dropped");
  reset_clean_a: assert property (
    $rose(aresetn) |-> !(s_axi_bvalid || s_axi_rvalid || nv_store_valid || device_reset_req))
    else $error("outputs after reset");
endmodule
`default_nettype wire

/* testbench/test_usb_activity_watchdog.sv */
// self-checking bench of the usb activity watchdog
`timescale 1ns/1ns
`default_nettype none
module test_usb_activity_watchdog;
  localparam int SC = 8;
  logic aclk = 1'h0, rn = 1'h0, awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0, rre = 1'h0;
  logic hc = 1'h0, strap = 1'h0, slow = 1'h0;
  logic [7:0] aw = 8'h00, ar = 8'h00;
  logic [31:0] wd = 32'h0, rd, v;
  logic [1:0] br, rr, r;
  logic awr, wrd, bv, arr, rv, nvv, nvr, dr, lw, llev, irq;
  logic [4:0] lsel;
  uawd_pkg::uawd_cfg_t nvs, nvl;
  int n_errors = 0, compares = 0, n_exp = 0, n, k;
  always #10 aclk = ~aclk;
  always @(negedge aclk) if (lw === 1'h1) n_exp++;
  uawd_top #(.SECOND_CYCLES(SC)) DUT (.aclk(aclk), .aresetn(rn), .s_axi_awaddr(aw),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ar), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rre), .host_cmd_pulse(hc), .strap_short(strap),
    .nv_load_data(nvl), .nv_store_data(nvs), .nv_store_valid(nvv), .nv_store_ready(nvr),
    .device_reset_req(dr), .expiry_line_write(lw), .expiry_line_select(lsel),
    .expiry_line_level(llev), .irq(irq));
  uawd_nv_model nv (.aclk(aclk), .slow(slow), .nv_store_data(nvs), .nv_store_valid(nvv),
    .nv_store_ready(nvr), .nv_load_data(nvl));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic test_done;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    aw <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bre <= 1'h1;
    do @(negedge aclk); while (awr !== 1'h1);
    @(posedge aclk);
    awv <= 1'h0;
    wv <= 1'h0;
    do @(negedge aclk); while (bv !== 1'h1);
    r = br;
    @(posedge aclk);
    bre <= 1'h0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    ar <= a;
    arv <= 1'h1;
    rre <= 1'h1;
    do @(negedge aclk); while (arr !== 1'h1);
    @(posedge aclk);
    arv <= 1'h0;
    do @(negedge aclk); while (rv !== 1'h1);
    v = rd;
    r = rr;
    @(posedge aclk);
    rre <= 1'h0;
  endtask
  task automatic rst(input logic s);
    @(posedge aclk);
    rn <= 1'h0;
    strap <= s;
    repeat (8) @(posedge aclk);
    rn <= 1'h1;
    repeat (3) @(posedge aclk);
    strap <= 1'h0;
  endtask
  task automatic wait_exp;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (lw !== 1'h1 && dr !== 1'h1 && n < 400);
  endtask
  task automatic t_regs;
    rdr(uawd_pkg::ADDR_ACTIVE);
    chk(v, 32'h0);
    rdr(8'h18);
    chk({r, v[29:0]}, {uawd_pkg::RESP_SLVERR, 30'h0});
    wr(8'h18, 32'h1);
    chk(r, uawd_pkg::RESP_SLVERR);
    wr(uawd_pkg::ADDR_IRQ_MASK, 32'h7);
    rdr(uawd_pkg::ADDR_IRQ_MASK);
    chk(v, 32'h7);
    $display("t_regs end");
  endtask
  task automatic t_expire;
    // line 10 is made an output by the host beforehand
    wr(uawd_pkg::ADDR_OPTIONS, 32'h0000_0A0E);
    wr(uawd_pkg::ADDR_CONFIG_REQ, 32'h0002_0001);
    repeat (10) @(posedge aclk);
    wr(uawd_pkg::ADDR_CONFIG_REQ, 32'h0002_0001);
    wait_exp();
    chk(n >= 2 * SC - 1 && n <= 2 * SC + 2, 1);
    chk({dr, lw, llev, lsel}, {3'h7, 5'h0A});
    chk(irq, 1'h1);
    rdr(uawd_pkg::ADDR_IRQ_STATUS);
    chk(v[0], 1'h1);
    rdr(uawd_pkg::ADDR_STATUS);
    chk(v[0], 1'h1);
    wr(uawd_pkg::ADDR_IRQ_STATUS, 32'h7);
    @(negedge aclk);
    chk(irq, 1'h0);
    $display("t_expire end");
  endtask
  task automatic t_restart;
    wr(uawd_pkg::ADDR_OPTIONS, 32'h0000_0304);
    wr(uawd_pkg::ADDR_CONFIG_REQ, 32'h0001_0001);
    k = n_exp;
    repeat (6) begin
      repeat (SC - 3) @(posedge aclk);
      // only host commands restart the count, no stream input exists
      hc <= 1'h1;
      @(posedge aclk);
      hc <= 1'h0;
    end
    chk(n_exp, k);
    wait_exp();
    chk(n >= SC - 1 && n <= SC + 2, 1);
    chk({dr, lw, llev, lsel}, {3'h2, 5'h03});
    $display("t_restart end");
  endtask
  task automatic t_disarm;
    repeat (4 * SC) @(posedge aclk);
    slow <= 1'h1;
    // both request bits: disarm must win
    wr(uawd_pkg::ADDR_CONFIG_REQ, 32'h0001_0003);
    k = n_exp;
    repeat (3 * SC) @(posedge aclk);
    chk(n_exp, k);
    rdr(uawd_pkg::ADDR_STATUS);
    chk(v[0], 1'h0);
    chk(nvl.armed, 1'h0);
    slow <= 1'h0;
    $display("t_disarm end");
  endtask
  task automatic t_badtime;
    wr(uawd_pkg::ADDR_IRQ_STATUS, 32'h7);
    wr(uawd_pkg::ADDR_CONFIG_REQ, 32'h0000_0001);
    rdr(uawd_pkg::ADDR_IRQ_STATUS);
    chk(v, 32'h4);
    chk(irq, 1'h1);
    wr(uawd_pkg::ADDR_IRQ_MASK, 32'h0);
    @(negedge aclk);
    chk(irq, 1'h0);
    wr(uawd_pkg::ADDR_IRQ_MASK, 32'h7);
    rdr(uawd_pkg::ADDR_ACTIVE);
    chk(v[0], 1'h0);
    wr(uawd_pkg::ADDR_CONFIG_REQ, 32'hFFFF_0001);
    rdr(uawd_pkg::ADDR_ACTIVE);
    chk({v[31:16], v[0]}, {16'hFFFF, 1'h1});
    $display("t_badtime end");
  endtask
  task automatic t_reload;
    repeat (4 * SC) @(posedge aclk);
    rst(1'h0);
    rdr(uawd_pkg::ADDR_ACTIVE);
    chk({v[31:16], v[0]}, {16'hFFFF, 1'h1});
    rst(1'h1);
    rdr(uawd_pkg::ADDR_ACTIVE);
    chk(v, 32'h0);
    repeat (8) @(posedge aclk);
    chk(nvl, uawd_pkg::CFG_FACTORY);
    $display("t_reload end");
  endtask
  initial begin
    rst(1'h0);
    t_regs;
    t_expire;
    t_restart;
    t_disarm;
    t_badtime;
    t_reload;
    test_done;
  end
  initial begin
    #400000;
    n_errors++;
    test_done;
  end
endmodule
bind uawd_top uawd_checker #(.SECOND_CYCLES(SECOND_CYCLES)) chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
  .s_axi_rready(s_axi_rready), .host_cmd_pulse(host_cmd_pulse),
  .nv_store_valid(nv_store_valid), .nv_store_ready(nv_store_ready),
  .device_reset_req(device_reset_req), .expiry_line_write(expiry_line_write),
  .expiry_line_select(expiry_line_select), .expiry_line_level(expiry_line_level));
`default_nettype wire
